// [core/cib_apb.sv]
`timescale 1ns/1ps
`default_nettype none

module cib_apb
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [cib_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            ctrl_en,
  input  wire logic                       busy,
  input  wire logic [2:0]                 fsm_state,
  input  wire logic [31:0]                retired,
  input  wire logic [15:0]                last_instr
);
  import cib_pkg::*;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        en;
  } cib_apb_s;

  cib_apb_s s;
  cib_apb_s next_s;

  always_comb
  begin
    next_s         = s;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    // First access cycle: prepare the answer, given one cycle later
    if (psel && penable && !s.pready)
    begin
      next_s.pready = 1'b1;
      case (paddr)
        REG_CTRL:    next_s.prdata = {31'h0, s.en};
        REG_STATUS:  next_s.prdata = {28'h0, fsm_state, busy};
        REG_RETIRED: next_s.prdata = retired;
        REG_LAST:    next_s.prdata = {16'h0, last_instr};
        default:
        begin
          next_s.prdata  = 32'h0;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    // Writes land on the completing edge only
    if (psel && penable && s.pready && pwrite && paddr == REG_CTRL)
    begin
      next_s.en = pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '{prdata: 32'h0, pready: 1'b0, pslverr: 1'b0, en: CTRL_RESET};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign ctrl_en = s.en;

endmodule

`default_nettype wire

// [core/cib_cond_eval.sv]
`timescale 1ns/1ps
`default_nettype none

module cib_cond_eval
(
  input  wire logic [3:0] cond,
  input  wire logic       flag_n,
  input  wire logic       flag_z,
  input  wire logic       flag_c,
  input  wire logic       flag_v,
  output logic            take
);
  import cib_pkg::*;

  always_comb
  begin
    case (cond)
      4'h0:    take = flag_z;
      4'h1:    take = !flag_z;
      4'h2:    take = flag_c;
      4'h3:    take = !flag_c;
      4'h4:    take = flag_n;
      4'h5:    take = !flag_n;
      4'h6:    take = flag_v;
      4'h7:    take = !flag_v;
      4'h8:    take = flag_c && !flag_z;
      4'h9:    take = !flag_c || flag_z;
      4'ha:    take = (flag_n == flag_v);
      4'hb:    take = (flag_n != flag_v);
      4'hc:    take = !flag_z && (flag_n == flag_v);
      4'hd:    take = flag_z || (flag_n != flag_v);
      default: take = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// [core/cib_core.sv]
// How it works
// - Select bit 0: store each listed low register from base, then write base back.
// - Select bit 1: load each listed low register from base, then write base back.
// - Address steps one word per register; final address becomes the new base.
// - Each compact instruction takes as many cycles as its wide equivalent.
// - Branch targets use the instruction address plus one word.
// - Code 0000 branches on zero set, 0001 on zero clear.
// - Code 0010 branches on carry set, 0011 on carry clear.
// - Code 0100 branches on negative set, 0101 on negative clear.
// - Code 0110 branches on overflow set, 0111 on overflow clear.
// - 1000: carry set and zero clear; 1001: carry clear or zero set.
// - 1010: negative equals overflow; 1011: they differ.
// - 1100: zero clear and N equals V; 1101: zero set or N differs from V.
// - Condition code 1111 is the software interrupt, not a branch.
// - Conditional offset is a signed halfword count, doubled before adding.
// - Software interrupt leaves compact state for wide state and supervisor mode.
// - Software interrupt saves return address and status word, jumps to vector 0x8.
// - Software interrupt immediate is ignored by the hardware.
// - Unconditional branch adds the signed 11-bit field doubled; reach is 2048 bytes.
// - Long branch with link is two halves, told apart by the select bit.
// - First half: offset shifted left 12 plus program counter goes to link register.
// - Second half: link plus offset doubled to program counter; link gets next, bit 0 set.
`timescale 1ns/1ps
`default_nettype none

module cib_core
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [cib_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       instr_valid,
  input  wire logic [15:0]                instr,
  input  wire logic [31:0]                instr_addr,
  output logic                            instr_ready,
  input  wire logic                       flag_n,
  input  wire logic                       flag_z,
  input  wire logic                       flag_c,
  input  wire logic                       flag_v,
  input  wire logic [31:0]                current_status_word,
  input  wire logic [31:0]                link_register,
  output logic      [2:0]                 rf_rd_idx,
  input  wire logic [31:0]                rf_rd_data,
  output logic                            rf_we,
  output logic      [3:0]                 rf_wr_idx,
  output logic      [31:0]                rf_wr_data,
  output logic                            pc_load,
  output logic      [31:0]                program_counter,
  output logic                            saved_status_we,
  output logic      [31:0]                saved_status_word,
  output logic                            supervisor_mode,
  output logic                            wide_state,
  output logic                            mem_req,
  output logic                            mem_we,
  output logic      [31:0]                mem_addr,
  output logic      [31:0]                mem_wdata,
  input  wire logic [31:0]                mem_rdata,
  input  wire logic                       mem_ack
);
  import cib_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    cib_state_e       st;
    logic [CNT_W-1:0] cnt;
    logic             rdy;
    logic [2:0]       rb;
    logic [7:0]       list;
    logic             is_load;
    logic [31:0]      addr;
    logic [2:0]       rd_idx;
    logic             rf_we;
    logic [3:0]       rf_wr_idx;
    logic [31:0]      rf_wr_data;
    logic             pc_load;
    logic [31:0]      pc_value;
    logic             ss_we;
    logic [31:0]      ss_word;
    logic             sup;
    logic             wide;
    logic             mem_req;
    logic             mem_we;
    logic [31:0]      mem_wdata;
    logic [31:0]      retired;
    logic [15:0]      last;
  } cib_core_s;

  cib_core_s s;
  cib_core_s next_s;

  logic        ctrl_en;
  logic        cond_take;
  logic        accept;
  logic        is_multi;
  logic        is_cond;
  logic        is_swi;
  logic        is_undef;
  logic        is_uncond;
  logic        is_long;
  logic [3:0]  cond_code;
  logic [7:0]  off8;
  logic [10:0] off11;
  logic [31:0] pc_base;
  logic [31:0] next_addr;
  logic [31:0] cond_target;
  logic [31:0] uncond_target;
  logic [31:0] long_high;
  logic [31:0] long_target;

  // Lowest register still to move; increasing address order
  function automatic logic [2:0] lowest(input logic [7:0] l);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (l[i])
      begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  cib_cond_eval u_cond
  (
    .cond   (cond_code),
    .flag_n (flag_n),
    .flag_z (flag_z),
    .flag_c (flag_c),
    .flag_v (flag_v),
    .take   (cond_take)
  );

  cib_apb u_apb
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .ctrl_en    (ctrl_en),
    .busy       (s.st != CIB_IDLE),
    .fsm_state  (s.st),
    .retired    (s.retired),
    .last_instr (s.last)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign cond_code = instr[F_COND_HI:F_COND_LO];
  assign off8      = instr[F_OFF8_HI:0];
  assign off11     = instr[F_OFF11_HI:0];
  assign accept    = instr_valid && s.rdy && (s.st == CIB_IDLE);
  assign is_multi  = (instr[OP_HI:OP4_LO] == OP_MULTI);
  assign is_cond   = (instr[OP_HI:OP4_LO] == OP_COND);
  assign is_swi    = is_cond && (cond_code == COND_SWI);
  assign is_undef  = is_cond && (cond_code == COND_UNDEF);
  assign is_uncond = (instr[OP_HI:OP5_LO] == OP_UNCOND);
  assign is_long   = (instr[OP_HI:OP4_LO] == OP_LONG);
  assign pc_base   = instr_addr + PC_AHEAD;
  assign next_addr = instr_addr + INSTR_BYTES;
  assign cond_target   = pc_base + {{23{off8[7]}}, off8, 1'b0};
  assign uncond_target = pc_base + {{20{off11[10]}}, off11, 1'b0};
  assign long_high     = pc_base + {{9{off11[10]}}, off11, 12'h0};
  assign long_target   = link_register + {20'h0, off11, 1'b0};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s         = s;
    next_s.rf_we   = 1'b0;
    next_s.pc_load = 1'b0;
    next_s.ss_we   = 1'b0;
    next_s.sup     = 1'b0;
    next_s.wide    = 1'b0;
    case (s.st)
      CIB_IDLE:
      begin
        if (accept)
        begin
          next_s.last    = instr;
          next_s.retired = s.retired + 32'h1;
          next_s.st      = CIB_EXEC;
          next_s.cnt     = CYC_NOT_TAKEN;
          if (is_multi)
          begin
            next_s.is_load = instr[F_SEL];
            next_s.rb      = instr[F_BASE_HI:F_BASE_LO];
            next_s.list    = instr[F_OFF8_HI:0];
            next_s.rd_idx  = instr[F_BASE_HI:F_BASE_LO];
            next_s.st      = CIB_BASE;
          end
          else if (is_swi)
          begin
            // Immediate byte is not looked at
            next_s.rf_we      = 1'b1;
            next_s.rf_wr_idx  = LINK_IDX;
            next_s.rf_wr_data = next_addr;
            next_s.ss_we      = 1'b1;
            next_s.ss_word    = current_status_word;
            next_s.pc_load    = 1'b1;
            next_s.pc_value   = SWI_VECTOR;
            next_s.sup        = 1'b1;
            next_s.wide       = 1'b1;
            next_s.cnt        = CYC_SWI;
          end
          else if (is_cond && !is_undef && cond_take)
          begin
            next_s.pc_load  = 1'b1;
            next_s.pc_value = cond_target;
            next_s.cnt      = CYC_TAKEN;
          end
          else if (is_uncond)
          begin
            next_s.pc_load  = 1'b1;
            next_s.pc_value = uncond_target;
            next_s.cnt      = CYC_TAKEN;
          end
          else if (is_long && !instr[F_SEL])
          begin
            next_s.rf_we      = 1'b1;
            next_s.rf_wr_idx  = LINK_IDX;
            next_s.rf_wr_data = long_high;
            next_s.cnt        = CYC_LONG_FIRST;
          end
          else if (is_long)
          begin
            next_s.pc_load    = 1'b1;
            next_s.pc_value   = long_target;
            next_s.rf_we      = 1'b1;
            next_s.rf_wr_idx  = LINK_IDX;
            next_s.rf_wr_data = next_addr | LINK_LSB;
            next_s.cnt        = CYC_LONG_SECND;
          end
        end
      end
      CIB_EXEC:
      begin
        next_s.cnt = s.cnt - 2'h1;
        if (s.cnt == CYC_NOT_TAKEN)
        begin
          next_s.st = CIB_IDLE;
        end
      end
      CIB_BASE:
      begin
        next_s.addr   = rf_rd_data;
        next_s.rd_idx = lowest(s.list);
        next_s.st     = (s.list == 8'h0) ? CIB_WB : CIB_ISSUE;
      end
      CIB_ISSUE:
      begin
        next_s.mem_req   = 1'b1;
        next_s.mem_we    = !s.is_load;
        next_s.mem_wdata = rf_rd_data;
        next_s.st        = CIB_WAIT;
      end
      CIB_WAIT:
      begin
        if (mem_ack)
        begin
          next_s.mem_req = 1'b0;
          next_s.mem_we  = 1'b0;
          next_s.addr    = s.addr + WORD_BYTES;
          next_s.list    = s.list & ~(8'h1 << s.rd_idx);
          if (s.is_load)
          begin
            next_s.rf_we      = 1'b1;
            next_s.rf_wr_idx  = {1'b0, s.rd_idx};
            next_s.rf_wr_data = mem_rdata;
          end
          next_s.rd_idx = lowest(next_s.list);
          next_s.st     = (next_s.list == 8'h0) ? CIB_WB : CIB_ISSUE;
        end
      end
      CIB_WB:
      begin
        next_s.rf_we      = 1'b1;
        next_s.rf_wr_idx  = {1'b0, s.rb};
        next_s.rf_wr_data = s.addr;
        next_s.st         = CIB_IDLE;
      end
      default:
      begin
        next_s.st = CIB_IDLE;
      end
    endcase
    next_s.rdy = ctrl_en && (next_s.st == CIB_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign instr_ready       = s.rdy;
  assign rf_rd_idx         = s.rd_idx;
  assign rf_we             = s.rf_we;
  assign rf_wr_idx         = s.rf_wr_idx;
  assign rf_wr_data        = s.rf_wr_data;
  assign pc_load           = s.pc_load;
  assign program_counter   = s.pc_value;
  assign saved_status_we   = s.ss_we;
  assign saved_status_word = s.ss_word;
  assign supervisor_mode   = s.sup;
  assign wide_state        = s.wide;
  assign mem_req           = s.mem_req;
  assign mem_we            = s.mem_we;
  assign mem_addr          = s.addr;
  assign mem_wdata         = s.mem_wdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mem_direction: assert property (mem_req |-> (mem_we == !s.is_load))
    else $error("transfer direction does not match select bit");
  a_load_writes: assert property (s.st == CIB_WAIT && mem_ack && s.is_load
    |=> rf_we && rf_wr_data == $past(mem_rdata))
    else $error("loaded word not written to register");
  a_addr_step: assert property (s.st == CIB_WAIT && mem_ack
    |=> mem_addr == $past(mem_addr) + WORD_BYTES)
    else $error("address did not advance by one word");
  a_base_written: assert property (s.st == CIB_WB
    |=> rf_we && rf_wr_idx == {1'b0, $past(s.rb)} && rf_wr_data == $past(s.addr))
    else $error("base not written back with final address");
  a_taken_cycles: assert property (accept && is_uncond
    |=> !instr_ready [*3])
    else $error("unconditional branch shorter than three cycles");
  a_cond_target: assert property (accept && is_cond && !is_swi && !is_undef
    && cond_take |=> pc_load && program_counter == $past(cond_target))
    else $error("conditional branch target wrong");
  a_not_taken: assert property (accept && is_cond && !cond_take && !is_swi
    |=> !pc_load ##1 instr_ready || !ctrl_en)
    else $error("untaken branch changed program counter or stalled");
  a_swi_entry: assert property (accept && is_swi
    |=> pc_load && program_counter == SWI_VECTOR && saved_status_we
        && rf_wr_idx == LINK_IDX && rf_wr_data == $past(next_addr))
    else $error("software interrupt entry wrong");
  a_swi_mode: assert property (accept && is_swi
    |=> supervisor_mode && wide_state ##1 !supervisor_mode)
    else $error("mode switch pulse wrong");
  a_uncond_target: assert property (accept && is_uncond
    |=> pc_load && program_counter == $past(uncond_target))
    else $error("unconditional target wrong");
  a_long_first: assert property (accept && is_long && !instr[F_SEL]
    |=> rf_we && !pc_load && rf_wr_data == $past(long_high))
    else $error("long branch first half wrong");
  a_long_second: assert property (accept && is_long && instr[F_SEL]
    |=> pc_load && rf_wr_data[0] && program_counter == $past(long_target))
    else $error("long branch second half wrong");

  c_multi_done: cover property (s.st == CIB_WB ##1 s.st == CIB_IDLE);
  c_swi: cover property (accept && is_swi);
  c_long_pair: cover property (accept && is_long && !instr[F_SEL]
    ##[1:8] accept && is_long && instr[F_SEL]);
  c_cond_taken: cover property (accept && is_cond && cond_take && !is_swi);

endmodule

`default_nettype wire

// [core/cib_pkg.sv]
package cib_pkg;

  // ----------------------------------------------------------------
  // Instruction field layout
  // ----------------------------------------------------------------
  localparam int         OP_HI       = 15;
  localparam int         OP4_LO      = 12;
  localparam int         OP5_LO      = 11;
  localparam logic [3:0] OP_MULTI    = 4'hc;
  localparam logic [3:0] OP_COND     = 4'hd;
  localparam logic [4:0] OP_UNCOND   = 5'h1c;
  localparam logic [3:0] OP_LONG     = 4'hf;
  localparam int         F_SEL       = 11;
  localparam int         F_BASE_HI   = 10;
  localparam int         F_BASE_LO   = 8;
  localparam int         F_COND_HI   = 11;
  localparam int         F_COND_LO   = 8;
  localparam int         F_OFF8_HI   = 7;
  localparam int         F_OFF11_HI  = 10;
  localparam logic [3:0] COND_UNDEF  = 4'he;
  localparam logic [3:0] COND_SWI    = 4'hf;

  // ----------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------
  localparam logic [31:0] PC_AHEAD    = 32'h0000_0004;
  localparam logic [31:0] INSTR_BYTES = 32'h0000_0002;
  localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
  localparam logic [31:0] SWI_VECTOR  = 32'h0000_0008;
  localparam logic [31:0] LINK_LSB    = 32'h0000_0001;
  localparam logic [3:0]  LINK_IDX    = 4'he;

  // ----------------------------------------------------------------
  // Cycle counts of the equivalent wide instructions
  // ----------------------------------------------------------------
  localparam int         CNT_W          = 2;
  localparam logic [1:0] CYC_TAKEN      = 2'h3;
  localparam logic [1:0] CYC_NOT_TAKEN  = 2'h1;
  localparam logic [1:0] CYC_SWI        = 2'h3;
  localparam logic [1:0] CYC_LONG_FIRST = 2'h1;
  localparam logic [1:0] CYC_LONG_SECND = 2'h3;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam int          APB_AW      = 12;
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_STATUS  = 12'h004;
  localparam logic [11:0] REG_RETIRED = 12'h008;
  localparam logic [11:0] REG_LAST    = 12'h00c;
  localparam logic        CTRL_RESET  = 1'b1;

  typedef enum logic [2:0] {
    CIB_IDLE,
    CIB_EXEC,
    CIB_BASE,
    CIB_ISSUE,
    CIB_WAIT,
    CIB_WB
  } cib_state_e;

endpackage

// [tb/cib_core_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module cib_core_tb_top;
  import cib_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic instr_valid = 1'b0, flag_n = 1'b0, flag_z = 1'b0, flag_c = 1'b0, flag_v = 1'b0;
  logic mem_ack = 1'b0, pready, pslverr, instr_ready, rf_we, pc_load, saved_status_we;
  logic supervisor_mode, wide_state, mem_req, mem_we, e;
  logic [11:0] paddr = 12'h000;
  logic [15:0] instr = 16'h0000;
  logic [2:0] rf_rd_idx;
  logic [3:0] rf_wr_idx;
  logic [31:0] pwdata = 32'h0, instr_addr = 32'h0, link_register = 32'h0;
  logic [31:0] current_status_word = 32'hd3, prdata, rf_rd_data, rf_wr_data, program_counter;
  logic [31:0] saved_status_word, mem_addr, mem_wdata, mem_rdata, rd;
  logic [31:0] regs [8];
  logic [31:0] mem [16];
  int n_fail = 0, comparisons = 0, n;

  cib_core cib_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr(instr), .instr_addr(instr_addr),
    .instr_ready(instr_ready), .flag_n(flag_n), .flag_z(flag_z), .flag_c(flag_c),
    .flag_v(flag_v), .current_status_word(current_status_word),
    .link_register(link_register), .rf_rd_idx(rf_rd_idx), .rf_rd_data(rf_rd_data),
    .rf_we(rf_we), .rf_wr_idx(rf_wr_idx), .rf_wr_data(rf_wr_data), .pc_load(pc_load),
    .program_counter(program_counter), .saved_status_we(saved_status_we),
    .saved_status_word(saved_status_word), .supervisor_mode(supervisor_mode),
    .wide_state(wide_state), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial forever #50 pclk = ~pclk;
  assign rf_rd_data = regs[rf_rd_idx];
  assign mem_rdata = ~mem_addr;

  // Register file, link register and memory around the core
  always @(posedge pclk)
  begin
    if (rf_we && !rf_wr_idx[3]) regs[rf_wr_idx[2:0]] <= rf_wr_data;
    if (rf_we && rf_wr_idx == 4'he) link_register <= rf_wr_data;
    if (mem_req && mem_we && !mem_ack) mem[mem_addr[5:2]] <= mem_wdata;
    mem_ack <= mem_req && !mem_ack;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      end_of_test();
    end
  endtask

  task automatic wt(output int c);
    c = 1;
    while (instr_ready !== 1'b1 && c < 99)
    begin
      @(posedge pclk);
      #1 c++;
    end
    if (instr_ready !== 1'b1)
    begin
      n_fail++;
      end_of_test();
    end
  endtask

  task automatic exe(input logic [15:0] i, input logic [31:0] a, input logic [3:0] f);
    int k;
    wt(k);
    @(posedge pclk);
    instr <= i;
    instr_addr <= a;
    instr_valid <= 1'b1;
    {flag_n, flag_z, flag_c, flag_v} <= f;
    @(posedge pclk);
    instr_valid <= 1'b0;
    #1;
  endtask

  function automatic logic tk(input logic [3:0] c, input logic [3:0] f);
    case (c[3:1])
      3'h0: tk = f[2];
      3'h1: tk = f[1];
      3'h2: tk = f[3];
      3'h3: tk = f[0];
      3'h4: tk = f[1] & !f[2];
      3'h5: tk = f[3] == f[0];
      default: tk = !f[2] & (f[3] == f[0]);
    endcase
    tk = tk ^ c[0];
  endfunction

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    for (int i = 0; i < 8; i++) regs[i] = {16'h0, i[3:0], 12'h000};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, REG_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    #1 chk("disabled", {31'h0, instr_ready}, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    $display("test apb done");
    for (int c = 0; c < 14; c++)
      for (int f = 0; f < 16; f++)
      begin
        e = tk(c[3:0], f[3:0]);
        exe({4'hd, c[3:0], 8'h80}, 32'h400, f[3:0]);
        if (c < 8)
          chk("cond", {31'h0, pc_load}, {31'h0, e});
        else chk("cond", {31'h0, pc_load}, {31'h0, e});
        if (e) chk("cond target", program_counter, 32'h304);
        wt(n);
        chk("cond cycles", n, e ? 32'h4 : 32'h2);
      end
    $display("test cond done");
    exe({5'h1c, 11'h400}, 32'h1000, 4'h0);
    chk("jump", program_counter, 32'h0000_0804);
    chk("jump load", {31'h0, pc_load}, 32'h1);
    wt(n);
    chk("jump cycles", n, 32'h4);
    for (int k = 0; k < 2; k++)
    begin
      exe({8'hdf, {8{k[0]}}}, 32'h100, 4'h0);
      chk("swi link", rf_wr_data, 32'h102);
      chk("swi", {25'h0, rf_we, rf_wr_idx, pc_load, saved_status_we}, 32'h7b);
      chk("swi mode", {30'h0, supervisor_mode, wide_state}, 32'h3);
      chk("swi vector", program_counter, 32'h8);
      chk("swi saved", saved_status_word, 32'hd3);
      wt(n);
      chk("swi cycles", n, 32'h4);
    end
    exe({5'h1e, 11'h7ff}, 32'h200, 4'h0);
    chk("long first", {rf_we, rf_wr_idx, pc_load}, 32'h3c);
    chk("long high", rf_wr_data, 32'hfffff204);
    wt(n);
    chk("long first cycles", n, 32'h2);
    exe({5'h1f, 11'h010}, 32'h202, 4'h0);
    chk("long target", program_counter, 32'hfffff224);
    chk("long return", rf_wr_data, 32'h205);
    wt(n);
    chk("long cycles", n, 32'h4);
    $display("test branch done");
    exe(16'hc218, 32'h300, 4'h0);
    wt(n);
    @(posedge pclk);
    #1 chk("store", {mem[0][15:0], mem[1][15:0]}, 32'h30004000);
    chk("store base", regs[2], 32'h2008);
    exe(16'hca60, 32'h302, 4'h0);
    wt(n);
    @(posedge pclk);
    #1 chk("load", {regs[5][15:0], regs[6][15:0]}, 32'hdff7dff3);
    chk("load base", regs[2], 32'h2010);
    apb(1'b0, REG_LAST, 32'h0);
    chk("last", rd, 32'h0000ca60);
    $display("test multiple done");
    end_of_test();
  end
endmodule
`default_nettype wire
